//--- inc/dio_pkg.sv
`default_nettype none
package dio_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned NLINES = 24;
  localparam int unsigned NGRP = 3;
  localparam int unsigned PAT_W = 16;
  localparam int unsigned LL_W = 16;
  localparam int unsigned DIV_W = 24;
  // One analog slot lasts 1 us
  localparam int unsigned SLOT_NS = 1000;
  localparam int unsigned SLOT_CYC =
    (SLOT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Fastest digital-only sampling and pattern rate
  localparam int unsigned DIG_MAX_HZ = 12_000_000;
  localparam int unsigned DIG_MIN_CYC =
    (CLK_HZ + DIG_MAX_HZ - 1) / DIG_MAX_HZ;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIN = 8'h04;
  localparam logic [7:0] OFS_DOUT = 8'h08;
  localparam logic [7:0] OFS_SCAN_DIV = 8'h0C;
  localparam logic [7:0] OFS_OUT_DIV = 8'h10;
  localparam logic [7:0] OFS_NCHAN = 8'h14;
  localparam logic [7:0] OFS_LL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam int unsigned CTL_DIR = 0;
  localparam int unsigned CTL_MODE = 3;
  localparam int unsigned CTL_SEL = 5;
  localparam int unsigned CTL_PAT = 8;
  localparam int unsigned CTL_PACE = 9;
  localparam int unsigned CTL_MASTER = 11;
  localparam int unsigned CTL_LL = 12;
  localparam int unsigned CTL_RUN = 13;
  localparam int unsigned LL_BIT_POS = 16;
  localparam int unsigned ST_UNDERRUN = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_PEND = 2;
  localparam int unsigned ST_LL = 3;
  localparam logic [DIV_W-1:0] SCAN_DIV_RST = 24'h00_0190;
  localparam logic [DIV_W-1:0] OUT_DIV_RST = 24'h00_0190;
  localparam logic [7:0] NCHAN_RST = 8'h00;
  localparam logic [LL_W-1:0] LL_LEVEL_RST = 16'h8000;
  typedef enum logic [1:0] {
    SCAN_OFF, SCAN_PER_SEQ, SCAN_PER_SLOT, SCAN_RSVD
  } scan_mode_e;
  typedef enum logic [1:0] {
    PACE_INT_ASYNC, PACE_INT_SYNC, PACE_EXT_ASYNC, PACE_EXT_SHARED
  } pace_e;
endpackage
`default_nettype wire

//--- rtl/pacer_div.sv
`default_nettype none
module pacer_div #(
  parameter logic [23:0] MIN_DIV = 24'h00_0001
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic [23:0] div,
  output logic tick
);
  logic [23:0] cnt;
  logic [23:0] lim;

  // Period never drops below the floor
  assign lim = (div < MIN_DIV) ? MIN_DIV : div;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 24'h00_0000;
      tick <= 1'b0;
    end else if (!en) begin
      cnt <= 24'h00_0000;
      tick <= 1'b0;
    end else if (cnt >= lim - 24'h00_0001) begin
      cnt <= 24'h00_0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 24'h00_0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/dio_scan_pattern.sv
`default_nettype none
module dio_scan_pattern (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [dio_pkg::NLINES-1:0] DIO_IN,
  output logic [dio_pkg::NLINES-1:0] DIO_OUT,
  output logic [dio_pkg::NLINES-1:0] DIO_OE_N,
  input wire logic EXT_PACER,
  output logic PACER_OUT,
  output logic [dio_pkg::NLINES-1:0] SAMP_DATA,
  output logic SAMP_VALID,
  output logic DMA_REQ,
  input wire logic DMA_ACK,
  input wire logic [dio_pkg::PAT_W-1:0] DMA_DATA,
  input wire logic [dio_pkg::LL_W-1:0] LL_VALUE,
  input wire logic LL_VALID
);
  import dio_pkg::*;

  typedef enum logic {S_IDLE, S_SLOT} scan_st_e;

  logic [NGRP-1:0] dir;
  scan_mode_e mode;
  logic [NGRP-1:0] sel;
  logic pat_en;
  pace_e pace;
  logic master;
  logic ll_en;
  logic run;
  logic [NLINES-1:0] dout;
  logic [DIV_W-1:0] scan_div;
  logic [DIV_W-1:0] out_div;
  logic [7:0] nchan;
  logic [LL_W-1:0] ll_level;
  logic [4:0] ll_bit;
  logic underrun;
  logic ll_out;
  logic [PAT_W-1:0] pend;
  logic [PAT_W-1:0] pat;
  logic pend_v;
  logic acc;
  logic wr_q;
  logic [7:0] a_q;
  logic ext_q;
  logic ext_edge;
  logic int_scan;
  logic out_tick;
  logic scan_start;
  logic pace_hit;
  logic upd;
  logic clr_under;
  scan_st_e st;
  logic [7:0] slot_idx;
  logic [7:0] slot_cnt;
  logic slot_start;
  logic samp_now;
  logic [NLINES-1:0] scan_mask;
  logic [NLINES-1:0] next_dout;
  logic [NLINES-1:0] next_oe_n;
  logic [31:0] next_rdata;

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign acc = HSEL && HREADY && HTRANS[1];
  assign clr_under = wr_q && (a_q == OFS_STATUS) && HWDATA[ST_UNDERRUN];

  // Address phase capture; writes land in the following data phase
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      wr_q <= acc && HWRITE && (HSIZE == 3'h2);
      a_q <= HADDR[7:0];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (HADDR[7:0])
      OFS_CTRL: begin
        next_rdata[CTL_DIR +: NGRP] = dir;
        next_rdata[CTL_MODE +: 2] = mode;
        next_rdata[CTL_SEL +: NGRP] = sel;
        next_rdata[CTL_PAT] = pat_en;
        next_rdata[CTL_PACE +: 2] = pace;
        next_rdata[CTL_MASTER] = master;
        next_rdata[CTL_LL] = ll_en;
        next_rdata[CTL_RUN] = run;
      end
      OFS_DIN: next_rdata[NLINES-1:0] = DIO_IN;
      OFS_DOUT: next_rdata[NLINES-1:0] = dout;
      OFS_SCAN_DIV: next_rdata[DIV_W-1:0] = scan_div;
      OFS_OUT_DIV: next_rdata[DIV_W-1:0] = out_div;
      OFS_NCHAN: next_rdata[7:0] = nchan;
      OFS_LL: begin
        next_rdata[LL_W-1:0] = ll_level;
        next_rdata[LL_BIT_POS +: 5] = ll_bit;
      end
      OFS_STATUS: begin
        next_rdata[ST_UNDERRUN] = underrun;
        next_rdata[ST_BUSY] = (st == S_SLOT);
        next_rdata[ST_PEND] = pend_v;
        next_rdata[ST_LL] = ll_out;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (acc && !HWRITE) begin
      HRDATA <= next_rdata;
    end
  end

  // Control registers; output latch writable in any state
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dir <= '0;
      mode <= SCAN_OFF;
      sel <= '0;
      pat_en <= 1'b0;
      pace <= PACE_INT_ASYNC;
      master <= 1'b0;
      ll_en <= 1'b0;
      run <= 1'b0;
      dout <= '0;
      scan_div <= SCAN_DIV_RST;
      out_div <= OUT_DIV_RST;
      nchan <= NCHAN_RST;
      ll_level <= LL_LEVEL_RST;
      ll_bit <= 5'h00;
    end else if (wr_q) begin
      case (a_q)
        OFS_CTRL: begin
          dir <= HWDATA[CTL_DIR +: NGRP];
          mode <= scan_mode_e'(HWDATA[CTL_MODE +: 2]);
          sel <= HWDATA[CTL_SEL +: NGRP];
          pat_en <= HWDATA[CTL_PAT];
          pace <= pace_e'(HWDATA[CTL_PACE +: 2]);
          master <= HWDATA[CTL_MASTER];
          ll_en <= HWDATA[CTL_LL];
          run <= HWDATA[CTL_RUN];
        end
        OFS_DOUT: dout <= HWDATA[NLINES-1:0];
        OFS_SCAN_DIV: scan_div <= HWDATA[DIV_W-1:0];
        OFS_OUT_DIV: out_div <= HWDATA[DIV_W-1:0];
        OFS_NCHAN: nchan <= HWDATA[7:0];
        OFS_LL: begin
          ll_level <= HWDATA[LL_W-1:0];
          ll_bit <= HWDATA[LL_BIT_POS +: 5];
        end
        default: ;
      endcase
    end
  end

  pacer_div #(.MIN_DIV(DIV_W'(DIG_MIN_CYC))) u_scan_pacer (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .en(run),
    .div(scan_div),
    .tick(int_scan)
  );

  pacer_div #(.MIN_DIV(DIV_W'(DIG_MIN_CYC))) u_out_pacer (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .en(run && pat_en),
    .div(out_div),
    .tick(out_tick)
  );

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= EXT_PACER;
    end
  end

  assign ext_edge = EXT_PACER && !ext_q;
  // Shared external clock paces the scans as well as the outputs
  assign scan_start = run &&
    ((pace == PACE_EXT_SHARED) ? ext_edge : int_scan);

  always_comb begin
    case (pace)
      PACE_INT_ASYNC: pace_hit = out_tick;
      PACE_INT_SYNC: pace_hit = scan_start;
      PACE_EXT_ASYNC: pace_hit = ext_edge;
      PACE_EXT_SHARED: pace_hit = scan_start;
      default: pace_hit = 1'b0;
    endcase
  end

  assign upd = run && pat_en && pace_hit;

  // Slot sequencer; a scan start during slots is an overrun, ignored
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= S_IDLE;
      slot_idx <= 8'h00;
      slot_cnt <= 8'h00;
    end else begin
      case (st)
        S_IDLE: begin
          slot_idx <= 8'h00;
          slot_cnt <= 8'h00;
          if (scan_start && nchan != 8'h00) begin
            st <= S_SLOT;
          end
        end
        S_SLOT: begin
          if (!run) begin
            st <= S_IDLE;
          end else if (slot_cnt == 8'(SLOT_CYC - 1)) begin
            slot_cnt <= 8'h00;
            slot_idx <= slot_idx + 8'h01;
            if (slot_idx == nchan - 8'h01) begin
              st <= S_IDLE;
            end
          end else begin
            slot_cnt <= slot_cnt + 8'h01;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  assign slot_start = (st == S_SLOT) && run && (slot_cnt == 8'h00);

  always_comb begin
    case (mode)
      SCAN_PER_SEQ: samp_now = scan_start;
      SCAN_PER_SLOT: samp_now = (nchan == 8'h00) ? scan_start
                                                 : slot_start;
      default: samp_now = 1'b0;
    endcase
  end

  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    // Only input groups that are picked join the scan
    assign scan_mask[g*8 +: 8] = {8{sel[g] && !dir[g]}};
    assign next_oe_n[g*8 +: 8] = {8{!dir[g]}};
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SAMP_DATA <= '0;
      SAMP_VALID <= 1'b0;
    end else begin
      SAMP_VALID <= samp_now;
      if (samp_now) begin
        SAMP_DATA <= DIO_IN & scan_mask;
      end
    end
  end

  // One-word holding slot refilled by DMA
  assign DMA_REQ = run && pat_en && !pend_v;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pend <= '0;
      pend_v <= 1'b0;
      pat <= '0;
    end else begin
      if (DMA_REQ && DMA_ACK) begin
        pend <= DMA_DATA;
        pend_v <= 1'b1;
      end else if (upd && pend_v) begin
        pat <= pend;
        pend_v <= 1'b0;
      end else if (!pat_en) begin
        pend_v <= 1'b0;
      end
    end
  end

  // Starved update keeps the old word; set beats clear
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      underrun <= 1'b0;
    end else if (upd && !pend_v) begin
      underrun <= 1'b1;
    end else if (clr_under) begin
      underrun <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ll_out <= 1'b0;
    end else if (ll_en && LL_VALID) begin
      ll_out <= (LL_VALUE > ll_level);
    end
  end

  always_comb begin
    next_dout = dout;
    if (pat_en) begin
      next_dout[PAT_W-1:0] = pat;
    end
    if (ll_en && ll_bit < 5'(NLINES)) begin
      next_dout[ll_bit] = ll_out;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DIO_OUT <= '0;
      DIO_OE_N <= '1;
      PACER_OUT <= 1'b0;
    end else begin
      DIO_OUT <= next_dout;
      DIO_OE_N <= next_oe_n;
      PACER_OUT <= master && scan_start;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_scan_go;
    st == S_IDLE && scan_start && nchan != 8'h00;
  endsequence

  sequence s_pat_load;
    upd && pend_v && !(DMA_REQ && DMA_ACK);
  endsequence

  chk_input_drv_off: assert property (
    !dir[0] |=> DIO_OE_N[7:0] == 8'hFF)
    else $error("input group 0 driver enabled");

  chk_output_drv_on: assert property (
    dir[2] |=> DIO_OE_N[23:16] == 8'h00)
    else $error("output group 2 driver off");

  chk_din_async: assert property (
    acc && !HWRITE && HADDR[7:0] == OFS_DIN
    |=> HRDATA == {8'h00, $past(DIO_IN)})
    else $error("async input read wrong");

  chk_dout_write: assert property (
    wr_q && a_q == OFS_DOUT && !pat_en && !ll_en && !dir[2]
    |=> ##1 DIO_OUT[23:16] == $past(HWDATA[23:16], 2))
    else $error("output latch not applied");

  chk_seq_sample: assert property (
    mode == SCAN_PER_SEQ && scan_start |=> SAMP_VALID)
    else $error("scan start sample missing");

  chk_slot_sample: assert property (
    s_scan_go ##1 (mode == SCAN_PER_SLOT && run)
    |=> SAMP_VALID)
    else $error("first slot sample missing");

  chk_slot_len: assert property (
    s_scan_go ##1 (run && nchan == 8'h02)[*8]
    |-> st == S_SLOT)
    else $error("slot sequence ended early");

  chk_fast_sample: assert property (
    mode == SCAN_PER_SLOT && nchan == 8'h00 && scan_start
    |=> SAMP_VALID ##1 !SAMP_VALID)
    else $error("digital-only sample wrong");

  chk_pat_load: assert property (
    s_pat_load |=> pat == $past(pend) ##1 DIO_OUT[15:0] == pat)
    else $error("pattern word not output");

  chk_dma_req: assert property (
    DMA_REQ && DMA_ACK |=> pend_v && !DMA_REQ && pend == $past(DMA_DATA))
    else $error("DMA word not held");

  chk_sync_update: assert property (
    pace == PACE_INT_SYNC && pat_en && int_scan && run
    |-> upd)
    else $error("scan-paced update missed");

  chk_async_update: assert property (
    pace == PACE_INT_ASYNC && out_tick && run && pat_en |-> upd)
    else $error("pacer update missed");

  chk_shared_clk: assert property (
    pace == PACE_EXT_SHARED && run && ext_edge |-> scan_start)
    else $error("shared clock not pacing scan");

  chk_low_latency: assert property (
    ll_en && LL_VALID |=> ll_out == ($past(LL_VALUE) > $past(ll_level)))
    else $error("low-latency bit wrong");

  chk_master_out: assert property (
    master && scan_start |=> PACER_OUT)
    else $error("master pacer not exported");

  chk_underrun_set: assert property (
    upd && !pend_v |=> underrun)
    else $error("starved update not flagged");
endmodule
`default_nettype wire

//--- bench/dma_host.sv
`default_nettype none
module dma_host (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  input wire logic stall,
  input wire logic [3:0] lag,
  output logic ack,
  output logic [15:0] data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sent[$];
  logic [7:0] k;
  logic [3:0] cnt;
  // Each request is answered with the next buffer word, after lag cycles
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      k <= 8'h00;
      data <= 16'h0000;
    end else if (ack) begin
      ack <= 1'b0;
      data <= ~data;
      cnt <= 4'h0;
    end else if (req && !stall && cnt >= lag) begin
      ack <= 1'b1;
      data <= {k + 8'h01, ~k};
      sent.push_back({k + 8'h01, ~k});
      k <= k + 8'h01;
    end else if (req && !stall) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- bench/digital_io_scan_pattern_gen_tb.sv
`default_nettype none
module digital_io_scan_pattern_gen_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dio_pkg::*;
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic HSEL = 1'b1;
  logic HWRITE = 1'b0;
  logic EXT_PACER = 1'b0;
  logic LL_VALID = 1'b0;
  logic [31:0] HADDR = 32'h0000_0000;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic [1:0] HTRANS = 2'b00;
  logic [2:0] HSIZE = 3'b010;
  logic [23:0] DIO_IN = 24'h00_0000;
  logic [15:0] LL_VALUE = 16'h0000;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, PACER_OUT, SAMP_VALID, DMA_REQ, DMA_ACK;
  logic [23:0] DIO_OUT, DIO_OE_N, SAMP_DATA;
  logic [15:0] DMA_DATA, pat_prev;
  logic stall = 1'b0;
  logic pchk = 1'b0;
  logic sv_prev;
  logic [3:0] lag = 4'h0;
  logic [1:0] pace = 2'b00;
  int seed = 32'h9e4b;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int last_upd = 0;
  int upd_n = 0;
  int exp_gap[4] = '{6, 8, 10, 10};
  int g[2];
  logic [31:0] r, v;
  logic [23:0] m;

  dio_scan_pattern dut_u (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .DIO_IN(DIO_IN), .DIO_OUT(DIO_OUT),
    .DIO_OE_N(DIO_OE_N), .EXT_PACER(EXT_PACER), .PACER_OUT(PACER_OUT),
    .SAMP_DATA(SAMP_DATA), .SAMP_VALID(SAMP_VALID), .DMA_REQ(DMA_REQ),
    .DMA_ACK(DMA_ACK), .DMA_DATA(DMA_DATA), .LL_VALUE(LL_VALUE),
    .LL_VALID(LL_VALID)
  );
  dma_host host_u (
    .clk(REF_CLK), .arst_n(ARST_N), .req(DMA_REQ), .stall(stall),
    .lag(lag), .ack(DMA_ACK), .data(DMA_DATA)
  );

  always #12.5 REF_CLK = ~REF_CLK;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic give_up(input string nm);
    fail_count++;
    $display("Error %s wait ran out", nm);
    close_out();
  endtask

  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) give_up("bus");
  endtask

  // Single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    HADDR <= {24'h00_0000, a};
    HTRANS <= 2'b10;
    HWRITE <= w;
    edge_rdy();
    HTRANS <= 2'b00;
    HWDATA <= d;
    edge_rdy();
    rd = HRDATA;
    chk("hresp", {HREADYOUT, HRESP}, 2'b10);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, r);
  endtask

  // Dividers change only while stopped
  task automatic cfg(input logic [31:0] sd, nc, c);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_SCAN_DIV, sd);
    wr(OFS_NCHAN, nc);
    wr(OFS_CTRL, c);
  endtask

  // Two consecutive intervals between pulses
  task automatic gap(input logic po);
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while ((po ? PACER_OUT : SAMP_VALID) !== 1'b1 && n < 2000);
    for (int i = 0; i < 2; i++) begin
      g[i] = 0;
      do begin
        @(posedge REF_CLK);
        g[i]++;
      end while ((po ? PACER_OUT : SAMP_VALID) !== 1'b1 && g[i] < 2000);
    end
    if (n >= 2000 || g[1] >= 2000 || g[0] >= 2000) give_up("pulse");
  endtask

  // Pattern model: buffer words in order, at the paced interval
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    EXT_PACER <= (cyc % 10) < 5;
    sv_prev <= SAMP_VALID;
    pat_prev <= DIO_OUT[15:0];
    if (pchk && DIO_OUT[15:0] !== pat_prev) begin
      chk("pattern", DIO_OUT[15:0], host_u.sent.pop_front());
      if (upd_n > 0) chk("pat_gap", cyc - last_upd, exp_gap[pace]);
      if (pace == 2'b01) chk("pat_scan", sv_prev, 1'b1);
      last_upd <= cyc;
      upd_n <= upd_n + 1;
    end
  end

  initial begin
    repeat (4) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    chk("oe_rst", DIO_OE_N, 24'hff_ffff);
    bus(1'b0, 8'h20, 32'h0000_0000, r);
    chk("unmapped", r, 32'h0000_0000);
    wr(OFS_OUT_DIV, 32'h0000_0006);
    for (int d = 0; d < 8; d++) begin
      v = $random(seed);
      wr(OFS_CTRL, 32'h0000_2008 | d);
      wr(OFS_DOUT, v);
      repeat (2) @(posedge REF_CLK);
      m = {{8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
      chk("oe_n", DIO_OE_N, {8'h00, ~m});
      chk("dout", DIO_OUT & m, v[23:0] & m);
    end
    v = $random(seed);
    DIO_IN <= v[23:0];
    cfg(32'h0000_0008, 32'h0000_0000, 32'h0000_2068);
    gap(1'b0);
    chk("samp", SAMP_DATA, DIO_IN & 24'h00_ffff);
    chk("mode1_gap", g[0] + g[1], 16);
    bus(1'b0, OFS_DIN, 32'h0000_0000, r);
    chk("din", r, {8'h00, DIO_IN});
    cfg(32'h0000_00c8, 32'h0000_0002, 32'h0000_2070);
    gap(1'b0);
    chk("slot_gaps", g[0] * g[1], 6400);
    cfg(32'h0000_0001, 32'h0000_0000, 32'h0000_2070);
    gap(1'b0);
    chk("fast_gap", g[0] + g[1], 8);
    cfg(32'h0000_0008, 32'h0000_0000, 32'h0000_2868);
    gap(1'b1);
    chk("pacer_out", g[0] + g[1], 16);
    cfg(32'h0000_0008, 32'h0000_0000, 32'h0000_2668);
    gap(1'b0);
    chk("shared_gap", g[0] + g[1], 20);
    wr(OFS_DOUT, 32'h0000_0000);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_CTRL, 32'h0000_0000);
      // Let a word acked at the stop edge fall away unused
      repeat (2) @(posedge REF_CLK);
      host_u.sent.delete();
      pace <= p[1:0];
      lag <= p[0] ? 4'h3 : 4'h0;
      upd_n <= 0;
      cfg(32'h0000_0008, 32'h0000_0000, 32'h0000_210b | (p << 9));
      // The previous run's word reappears on enable; skip that step
      repeat (2) @(posedge REF_CLK);
      pchk <= 1'b1;
      repeat (150) @(posedge REF_CLK);
      pchk <= 1'b0;
      chk("pat_updates", upd_n > 10, 1'b1);
    end
    stall <= 1'b1;
    cfg(32'h0000_0008, 32'h0000_0000, 32'h0000_2103);
    repeat (40) @(posedge REF_CLK);
    bus(1'b0, OFS_STATUS, 32'h0000_0000, r);
    chk("underrun", r[0], 1'b1);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0001);
    bus(1'b0, OFS_STATUS, 32'h0000_0000, r);
    chk("underrun_clr", r[0], 1'b0);
    stall <= 1'b0;
    wr(OFS_CTRL, 32'h0000_1001);
    wr(OFS_LL, 32'h0003_1000);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      LL_VALUE <= v[15:0];
      LL_VALID <= 1'b1;
      @(posedge REF_CLK);
      LL_VALID <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      chk("ll_bit", DIO_OUT[3], v[15:0] > 16'h1000);
    end
    close_out();
  end
endmodule
`default_nettype wire
